/* File: rrd_top.sv */
// receive recovery divider configuration: registers, pin presets, selection
// Contract
// - the recovery frequency plan is set by reference, main, fractional and octave dividers.
// - the octave code 0 to 6 selects an octave divide of 1 to 64, halving the rate span each step.
// - the octave code is a 3-bit field of the register at c0h.
// - the 9-bit main divider is split over the registers at c1h and c2h.
// - the 22-bit fractional divider is spread over the registers at c3h to c5h.
// - a no-fraction flag in c3h selects integer division when set.
// - without bus configuration the settings come from three rate-select pins at 19.44 MHz.
// - rate codes 0 to 7 map to 155.52, 622.08, 2488.32, 2666.06, 1250, 3125, 1062.5, 2125.
// - the reference divider comes from the 3-bit field of a1h in bus mode, else two pins.
`timescale 1ns/1ns
module rrd_top (
    input wire logic clk_i,              // 100 mhz clock
    input wire logic rst_i,              // async reset, active high
    input wire logic bus_mode_i,         // 1: settings from registers
    input wire logic [7:0] reg_addr_i,   // register offset
    input wire logic reg_wr_i,           // write strobe
    input wire logic [7:0] reg_wdata_i,  // write data
    input wire logic reg_rd_i,           // read strobe
    output logic [7:0] reg_rdata_o,      // read data, one cycle after strobe
    input wire logic rate_sel0_i,        // rate-select pin 0
    input wire logic rate_sel1_i,        // rate-select pin 1
    input wire logic rate_sel2_i,        // rate-select pin 2
    input wire logic [2:0] ref_div_select_field_i, // a1h field from register block
    input wire logic [1:0] fref_pins_i,  // frequency-select pins {1,0}
    output logic [2:0] octave_div_o,     // active octave code
    output logic [6:0] octave_ratio_o,   // active octave divide value
    output logic [5:0] ref_div_o,        // active reference divide value
    output logic [8:0] main_div_o,       // active main divider
    output logic [21:0] frac_div_o,      // active fractional divider
    output logic no_fraction_o           // 1: integer division
);

    // ****************************************************************
    // state
    // ****************************************************************
    // register fields first, then the registered copies that feed the outputs
    typedef struct packed {
        logic [2:0] octave_div_field;
        logic [8:0] main_div_field;
        logic [21:0] frac_div_field;
        logic no_fraction_flag;
        logic [7:0] rdata;
        logic [2:0] oct_out;
        logic [6:0] ratio_out;
        logic [5:0] ref_out;
        logic [8:0] main_out;
        logic [21:0] frac_out;
        logic nofrac_out;
    } rrd_state_t;

    rrd_state_t s_q;
    rrd_state_t s_d;

    logic [2:0] p_oct;
    logic [8:0] p_main;
    logic [21:0] p_frac;
    logic p_nofrac;

    // ****************************************************************
    // write decode
    // ****************************************************************
    logic wr_octave;
    logic wr_main_hi;
    logic wr_main_lo;
    logic wr_frac_hi;
    logic wr_frac_mid;
    logic wr_frac_lo;

    // one strobe per mapped byte; unmapped offsets raise none, so they are ignored
    assign wr_octave = reg_wr_i && (reg_addr_i == rrd_pkg::OFS_OCTAVE);
    assign wr_main_hi = reg_wr_i && (reg_addr_i == rrd_pkg::OFS_MAIN_HI);
    assign wr_main_lo = reg_wr_i && (reg_addr_i == rrd_pkg::OFS_MAIN_LO);
    assign wr_frac_hi = reg_wr_i && (reg_addr_i == rrd_pkg::OFS_FRAC_HI);
    assign wr_frac_mid = reg_wr_i && (reg_addr_i == rrd_pkg::OFS_FRAC_MID);
    assign wr_frac_lo = reg_wr_i && (reg_addr_i == rrd_pkg::OFS_FRAC_LO);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the byte lanes below are cut for these widths; refuse any other constants
    if (rrd_pkg::OCT_W != 3 || rrd_pkg::MAIN_W != 9) begin : g_int_width
        $error("octave or main divider width does not fit its byte lanes");
    end
    if (rrd_pkg::FRAC_W != 22 || rrd_pkg::FRAC_HI_W != 6) begin : g_frac_width
        $error("fraction width does not fit its three byte lanes");
    end
    // the no-fraction flag must sit above the fraction bits of its byte
    if (rrd_pkg::NOFRAC_BIT < rrd_pkg::FRAC_HI_W || rrd_pkg::NOFRAC_BIT > 7) begin : g_flag_pos
        $error("no-fraction flag overlaps the fraction bits");
    end

    // ****************************************************************
    // pin presets
    // ****************************************************************
    // pin preset table
    rrd_preset_rom u_rom (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .code_i({rate_sel2_i, rate_sel1_i, rate_sel0_i}),
        .octave_o(p_oct),
        .main_o(p_main),
        .frac_o(p_frac),
        .nofrac_o(p_nofrac)
    );

    // ****************************************************************
    // register writes, reads and output selection
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        // bytes land one at a time, so a multi-byte divider change shows
        // a mixed value on the outputs until its last byte is written
        // octave field write
        if (wr_octave) begin
            s_d.octave_div_field = reg_wdata_i[2:0];
        end
        if (wr_main_hi) begin
            s_d.main_div_field[8] = reg_wdata_i[0];
        end
        if (wr_main_lo) begin
            s_d.main_div_field[7:0] = reg_wdata_i;
        end
        if (wr_frac_hi) begin
            s_d.no_fraction_flag = reg_wdata_i[rrd_pkg::NOFRAC_BIT];
            s_d.frac_div_field[21:16] = reg_wdata_i[5:0];
        end
        if (wr_frac_mid) begin
            s_d.frac_div_field[15:8] = reg_wdata_i;
        end
        if (wr_frac_lo) begin
            s_d.frac_div_field[7:0] = reg_wdata_i;
        end
        // read mux; unmapped offsets and idle cycles return zero
        // a read in the cycle of a write to the same byte returns the old value
        s_d.rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                rrd_pkg::OFS_OCTAVE: s_d.rdata = {5'h00, s_q.octave_div_field};
                rrd_pkg::OFS_MAIN_HI: s_d.rdata = {7'h00, s_q.main_div_field[8]};
                rrd_pkg::OFS_MAIN_LO: s_d.rdata = s_q.main_div_field[7:0];
                rrd_pkg::OFS_FRAC_HI: s_d.rdata = {s_q.no_fraction_flag, 1'b0,
                                                   s_q.frac_div_field[21:16]};
                rrd_pkg::OFS_FRAC_MID: s_d.rdata = s_q.frac_div_field[15:8];
                rrd_pkg::OFS_FRAC_LO: s_d.rdata = s_q.frac_div_field[7:0];
                default: s_d.rdata = 8'h00;
            endcase
        end
        // choose source of the frequency plan
        // a mode switch shows one cycle later; a rate-select pin change takes two cycles, through the table flop; a reference pin change takes one
        if (bus_mode_i) begin
            s_d.oct_out = s_q.octave_div_field;
            s_d.main_out = s_q.main_div_field;
            s_d.frac_out = s_q.frac_div_field;
            s_d.nofrac_out = s_q.no_fraction_flag;
        end else begin
            s_d.oct_out = p_oct;
            s_d.main_out = p_main;
            s_d.frac_out = p_frac;
            s_d.nofrac_out = p_nofrac;
        end
        // octave divide is a power of two; codes 7 clamp to 64
        // code 7 names no octave; clamping keeps the slowest legal divide, not 1
        if (s_d.oct_out > 3'h6) begin
            s_d.ratio_out = 7'h40;
        end else begin
            s_d.ratio_out = 7'(7'h01 << s_d.oct_out);
        end
        if (s_d.nofrac_out) begin
            s_d.frac_out = rrd_pkg::RST_FRAC;
        end
        // reference divide from field or pins; bad codes fall back to one
        // the pins reach four of the six ranges, the field reaches all six
        if (bus_mode_i) begin
            if (ref_div_select_field_i > rrd_pkg::REF_CODE_MAX) begin
                s_d.ref_out = rrd_pkg::REF_DIV_ONE;
            end else begin
                s_d.ref_out = 6'(rrd_pkg::REF_DIV_ONE << ref_div_select_field_i);
            end
        end else begin
            case (fref_pins_i)
                2'h3: s_d.ref_out = 6'h01;
                2'h2: s_d.ref_out = 6'h02;
                2'h1: s_d.ref_out = 6'h08;
                default: s_d.ref_out = 6'h20;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{rrd_pkg::RST_OCTAVE, rrd_pkg::RST_MAIN, rrd_pkg::RST_FRAC,
                     rrd_pkg::RST_NOFRAC, 8'h00, rrd_pkg::RST_OCTAVE, 7'h01,
                     rrd_pkg::REF_DIV_ONE, rrd_pkg::RST_MAIN, rrd_pkg::RST_FRAC,
                     rrd_pkg::RST_NOFRAC};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops, so the synthesizer never sees decode glitches
    assign reg_rdata_o = s_q.rdata;
    assign octave_div_o = s_q.oct_out;
    assign octave_ratio_o = s_q.ratio_out;
    assign ref_div_o = s_q.ref_out;
    assign main_div_o = s_q.main_out;
    assign frac_div_o = s_q.frac_out;
    assign no_fraction_o = s_q.nofrac_out;

endmodule

/* File: rrd_pkg.sv */
// constants for the receive recovery divider configuration block
package rrd_pkg;

    // ****************************************************************
    // register offsets (byte-wide register port)
    // ****************************************************************
    localparam logic [7:0] OFS_OCTAVE = 8'hc0;
    localparam logic [7:0] OFS_MAIN_HI = 8'hc1;
    localparam logic [7:0] OFS_MAIN_LO = 8'hc2;
    localparam logic [7:0] OFS_FRAC_HI = 8'hc3;
    localparam logic [7:0] OFS_FRAC_MID = 8'hc4;
    localparam logic [7:0] OFS_FRAC_LO = 8'hc5;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int OCT_W = 3;
    localparam int MAIN_W = 9;
    localparam int FRAC_W = 22;
    localparam int NOFRAC_BIT = 7;
    localparam int FRAC_HI_W = 6;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [2:0] RST_OCTAVE = 3'h0;
    localparam logic [8:0] RST_MAIN = 9'h100;
    localparam logic [21:0] RST_FRAC = 22'h000000;
    localparam logic RST_NOFRAC = 1'b1;

    // ****************************************************************
    // preset table for the rate-select pins, 19.44 MHz reference, r = 1
    // ****************************************************************
    localparam logic [2:0] P_OCT [8] = '{3'h4, 3'h2, 3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
    localparam logic [8:0] P_MAIN [8] = '{9'h100, 9'h100, 9'h100, 9'h111,
                                          9'h100, 9'h141, 9'h0da, 9'h0da};
    localparam logic [21:0] P_FRAC [8] = '{22'h000000, 22'h000000, 22'h000000, 22'h2926fb,
                                           22'h2673e3, 22'h1010db, 22'h13e281, 22'h13e281};
    localparam logic P_NOFRAC [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

    // ****************************************************************
    // reference divider codes
    // ****************************************************************
    localparam logic [2:0] REF_CODE_MAX = 3'h5;
    localparam logic [5:0] REF_DIV_ONE = 6'h01;

endpackage

/* File: rrd_preset_rom.sv */
// preset divider table addressed by the rate-select pin code
`timescale 1ns/1ns
module rrd_preset_rom (
    input wire logic clk_i,          // 100 mhz clock
    input wire logic rst_i,          // async reset, active high
    input wire logic [2:0] code_i,   // rate-select code
    output logic [2:0] octave_o,     // octave code
    output logic [8:0] main_o,       // main divider
    output logic [21:0] frac_o,      // fractional divider
    output logic nofrac_o            // integer division
);

    typedef struct packed {
        logic [2:0] octave;
        logic [8:0] main;
        logic [21:0] frac;
        logic nofrac;
    } rrd_rom_t;

    rrd_rom_t s_q;
    rrd_rom_t s_d;

    // rate code lookup, registered so outputs come from flops
    always_comb begin
        s_d.octave = rrd_pkg::P_OCT[code_i];
        s_d.main = rrd_pkg::P_MAIN[code_i];
        s_d.frac = rrd_pkg::P_FRAC[code_i];
        s_d.nofrac = rrd_pkg::P_NOFRAC[code_i];
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '{rrd_pkg::RST_OCTAVE, rrd_pkg::RST_MAIN, rrd_pkg::RST_FRAC,
                     rrd_pkg::RST_NOFRAC};
        end else begin
            s_q <= s_d;
        end
    end

    assign octave_o = s_q.octave;
    assign main_o = s_q.main;
    assign frac_o = s_q.frac;
    assign nofrac_o = s_q.nofrac;

endmodule

/* File: rrd_top_chk.sv */
// assertion checker for the receive recovery divider block
`timescale 1ns/1ns
module rrd_top_chk (
    input wire logic clk_i,                      // clock
    input wire logic rst_i,                      // reset
    input wire logic bus_mode_i,                 // register mode
    input wire logic [7:0] reg_addr_i,           // offset
    input wire logic reg_wr_i,                   // write strobe
    input wire logic [7:0] reg_wdata_i,          // write data
    input wire logic reg_rd_i,                   // read strobe
    input wire logic [7:0] reg_rdata_o,          // read data
    input wire logic rate_sel0_i,                // rate pin 0
    input wire logic rate_sel1_i,                // rate pin 1
    input wire logic rate_sel2_i,                // rate pin 2
    input wire logic [2:0] ref_div_select_field_i, // ref field
    input wire logic [1:0] fref_pins_i,          // ref pins
    input wire logic [2:0] octave_div_o,         // octave code
    input wire logic [6:0] octave_ratio_o,       // octave divide
    input wire logic [5:0] ref_div_o,            // ref divide
    input wire logic [8:0] main_div_o,           // main divider
    input wire logic [21:0] frac_div_o,          // fraction
    input wire logic no_fraction_o               // integer mode
);
    // ****************************************************************
    // properties, all in the one clock domain
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ratio_map_a: assert property (
        octave_ratio_o == ((octave_div_o == 3'h7) ? 7'h40 : 7'h01 << octave_div_o))
        else $error("octave ratio does not match code");
    nofrac_zero_a: assert property (
        no_fraction_o |-> frac_div_o == 22'h000000) else $error("fraction not cleared");
    octave_write_a: assert property (
        bus_mode_i && reg_wr_i && reg_addr_i == 8'hc0 ##1 bus_mode_i
        |=> octave_div_o == $past(reg_wdata_i[2:0], 2)) else $error("octave write lost");
    main_write_a: assert property (
        bus_mode_i && reg_wr_i && reg_addr_i == 8'hc2 ##1 bus_mode_i
        |=> main_div_o[7:0] == $past(reg_wdata_i, 2)) else $error("main low write lost");
    frac_write_a: assert property (
        bus_mode_i && reg_wr_i && reg_addr_i == 8'hc5 ##1 bus_mode_i
        |=> no_fraction_o || frac_div_o[7:0] == $past(reg_wdata_i, 2))
        else $error("fraction low write lost");
    idle_rdata_a: assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data without read");
    unmapped_read_a: assert property (
        reg_rd_i && (reg_addr_i < 8'hc0 || reg_addr_i > 8'hc5) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    pin_preset_a: assert property (
        (!bus_mode_i && {rate_sel2_i, rate_sel1_i, rate_sel0_i} == 3'h3) [*3]
        |-> {octave_div_o, main_div_o, frac_div_o, no_fraction_o}
        == {3'h0, 9'h111, 22'h2926fb, 1'b0}) else $error("pin preset wrong");
    ref_pins_a: assert property (
        !bus_mode_i && fref_pins_i == 2'h1 |=> ref_div_o == 6'h08) else $error("ref pins");
    ref_field_a: assert property (
        bus_mode_i && ref_div_select_field_i == 3'h4 |=> ref_div_o == 6'h10)
        else $error("ref field");
endmodule
bind rrd_top rrd_top_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .bus_mode_i(bus_mode_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rate_sel0_i(rate_sel0_i),
    .rate_sel1_i(rate_sel1_i), .rate_sel2_i(rate_sel2_i),
    .ref_div_select_field_i(ref_div_select_field_i), .fref_pins_i(fref_pins_i),
    .octave_div_o(octave_div_o), .octave_ratio_o(octave_ratio_o), .ref_div_o(ref_div_o),
    .main_div_o(main_div_o), .frac_div_o(frac_div_o), .no_fraction_o(no_fraction_o));

/* File: rrd_host.sv */
// register host model driving the byte register port
`timescale 1ns/1ns
module rrd_host (
    input wire logic clk_i,         // clock
    input wire logic [7:0] rdata_i, // read data
    output logic [7:0] addr_o,      // offset
    output logic [7:0] wdata_o,     // write data
    output logic wr_o,              // write strobe
    output logic rd_o               // read strobe
);
    // idle port at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // write one byte, then show inverted lines so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= v;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~v;
    endtask
    // read data lands one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1 v = rdata_i;
    endtask
endmodule

/* File: rrd_top_tb.sv */
// self-checking testbench for the receive recovery divider block
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module rrd_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bus_mode_i = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [2:0] field = 3'h0;
    logic [1:0] fref = 2'h3;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, nof;
    logic [2:0] oct;
    logic [6:0] ratio;
    logic [5:0] rdiv;
    logic [8:0] main;
    logic [21:0] frac;
    int mismatches = 0;
    int check_count = 0;
    logic [7:0] rst_rd [6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00};
    logic [5:0] pref [4] = '{6'h20, 6'h08, 6'h02, 6'h01};
    logic [34:0] pexp [8] = '{{3'h4, 9'h100, 22'h0, 1'b1}, {3'h2, 9'h100, 22'h0, 1'b1},
        {3'h0, 9'h100, 22'h0, 1'b1}, {3'h0, 9'h111, 22'h2926fb, 1'b0},
        {3'h1, 9'h100, 22'h2673e3, 1'b0}, {3'h0, 9'h141, 22'h1010db, 1'b0},
        {3'h1, 9'h0da, 22'h13e281, 1'b0}, {3'h0, 9'h0da, 22'h13e281, 1'b0}};
    rrd_host i_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    rrd_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_mode_i(bus_mode_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .rate_sel0_i(sel[0]), .rate_sel1_i(sel[1]), .rate_sel2_i(sel[2]),
        .ref_div_select_field_i(field), .fref_pins_i(fref), .octave_div_o(oct),
        .octave_ratio_o(ratio), .ref_div_o(rdiv), .main_div_o(main), .frac_div_o(frac),
        .no_fraction_o(nof));
    // 100 mhz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // outputs and registers at their values after reset
    task automatic check_reset;
        settle(2);
        `CHK({oct, ratio, rdiv, main, frac, nof}, {3'h0, 7'h01, 6'h01, 9'h100, 22'h0, 1'b1})
        for (int i = 0; i < 6; i++) begin
            i_host.rd(8'hc0 + i[7:0], d);
            `CHK(d, rst_rd[i])
        end
    endtask
    // host side: load a worked frequency plan {oct, n, k, flag} byte by byte
    task automatic load_plan(input logic [34:0] e);
        i_host.wr(8'hc0, {5'h00, e[34:32]});
        i_host.wr(8'hc1, {7'h00, e[31]});
        i_host.wr(8'hc2, e[30:23]);
        i_host.wr(8'hc3, {e[0], 1'b0, e[22:17]});
        i_host.wr(8'hc4, e[16:9]);
        i_host.wr(8'hc5, e[8:1]);
        settle(2);
    endtask
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        check_reset();
        // every octave code, reserved bits set on write
        for (int c = 0; c < 8; c++) begin
            i_host.wr(8'hc0, {5'h1f, c[2:0]});
            settle(2);
            `CHK({oct, ratio}, {c[2:0], (c == 7) ? 7'h40 : 7'h01 << c})
            i_host.rd(8'hc0, d);
            `CHK(d, {5'h00, c[2:0]})
        end
        // ratio 146.93 corrected to n 293, odd fraction
        i_host.wr(8'hc1, 8'hff);
        i_host.wr(8'hc2, 8'h25);
        i_host.wr(8'hc3, 8'h5b);
        i_host.wr(8'hc4, 8'h51);
        i_host.wr(8'hc5, 8'h2b);
        settle(2);
        `CHK({main, frac, nof}, {9'h125, 22'h1b512b, 1'b0})
        i_host.rd(8'hc1, d);
        `CHK(d, 8'h01)
        i_host.rd(8'hc3, d);
        `CHK(d, 8'h1b)
        i_host.wr(8'hc3, 8'h9b);
        settle(2);
        `CHK({frac, nof}, {22'h0, 1'b1})
        i_host.wr(8'hc6, 8'h55);
        i_host.rd(8'hc6, d);
        `CHK(d, 8'h00)
        // worked plans at 19.44 MHz, r = 1: zero, large and small fractions
        load_plan(pexp[2]);
        `CHK({oct, main, frac, nof}, pexp[2])
        load_plan(pexp[3]);
        `CHK({oct, main, frac, nof}, pexp[3])
        load_plan(pexp[6]);
        `CHK({oct, main, frac, nof}, pexp[6])
        for (int f = 0; f < 8; f++) begin
            @(posedge clk_i);
            field <= f[2:0];
            settle(2);
            `CHK(rdiv, (f < 6) ? 6'h01 << f : 6'h01)
        end
        // mid-run reset must bring every register back to its reset value
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        check_reset();
        // pin strapping mode
        @(posedge clk_i);
        bus_mode_i <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_i);
            fref <= p[1:0];
            settle(2);
            `CHK(rdiv, pref[p])
        end
        for (int s = 0; s < 8; s++) begin
            @(posedge clk_i);
            sel <= s[2:0];
            settle(3);
            `CHK({oct, main, frac, nof}, pexp[s])
        end
        final_report();
    end
endmodule
